//--- core/char_video_pkg.sv
package char_video_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS      = 5;
    localparam int DOT_NS      = 105;
    localparam int DOT_CYC     = (DOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CHAR_DOTS   = 6;
    localparam int CHAR_NS     = DOT_NS * CHAR_DOTS;
    localparam int HSYNC_NS    = 5000;
    localparam int HSYNC_CHARS = (HSYNC_NS + CHAR_NS / 2) / CHAR_NS;
    localparam int LINE_NS     = CHAR_NS * 100;
    localparam int VSYNC_NS    = 1000000;
    localparam int VSYNC_LINES = (VSYNC_NS + LINE_NS / 2) / LINE_NS;

    // ----------------------------------------------------------------
    // raster points
    // ----------------------------------------------------------------
    localparam logic [6:0] CHAR_BLANK  = 7'h50;  // 80
    localparam logic [6:0] CHAR_LAST   = 7'h63;  // 99, wraps at 100
    localparam logic [3:0] ROW_GAP     = 4'h8;
    localparam logic [3:0] CUR_LO      = 4'hA;
    localparam logic [3:0] CUR_HI      = 4'hB;
    localparam logic [3:0] RAS_LAST    = 4'hF;   // wraps at 16
    localparam logic [8:0] FRAME_BLANK = 9'h080; // 128
    localparam logic [8:0] VSYNC_LINE  = 9'h0B0; // 176
    localparam logic [8:0] FRAME_LINES = 9'h106; // 262
    localparam logic [3:0] BLINK_LAST  = 4'hE;   // toggle every 15 frames
    localparam logic [5:0] END_MESSAGE_CODE = 6'h3F;

    // ----------------------------------------------------------------
    // register map and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_CURSOR     = 8'h04;
    localparam logic [7:0] OFF_GLYPH_ADDR = 8'h08;
    localparam logic [7:0] OFF_GLYPH_DATA = 8'h0C;
    localparam logic [7:0] OFF_STATUS     = 8'h10;
    localparam logic [1:0] CTRL_RST       = 2'h3;
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_BLINK_BIT = 1;
    localparam int CUR_ROW_POS    = 8;
    localparam int STAT_BLINK_POS = 16;

    typedef struct packed {
        logic [4:0] row;
        logic [6:0] col;
    } cursor_pos_t;

endpackage : char_video_pkg

//--- core/text_raster_video.sv
// Operation
// - each machine cycle load five dots, then a zero, then a one
// - shift one dot per master dot clock tick toward video
// - reload when sentinel one reaches the end and all outputs high
// - the loaded zero blocks a false reload on all-ones dots
// - character counter advances once per character at end of T6
// - at count 80 drop display-active and video enable
// - active-low hsync about 5 us, once per 63 us line
// - at count 100 bump raster line, restart count, reenable video
// - raster lines 8 to 15 load all ones, so blank
// - lines 10 and 11 draw a solid cursor bar on match
// - raster counter reaching 16 bumps the display-line counter
// - from raster line 128 video enable stays off
// - active-low vsync about 1 ms from line 176, separate pin
// - at line 262 clear both line counters, new frame
// - frame end drives divider giving 2 per second cursor blink
// - end-of-message code shows as a lit block 5 by 8
// - character code gathered two bits per dot tick, three ticks in one memory clock pulse
// - glyph table gives five dots for character and matrix line
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module text_raster_video
    import char_video_pkg::*;
(
    input  wire logic        pclk,               // 200 MHz clock
    input  wire logic        presetn,            // async reset, low
    input  wire logic        psel,               // apb select
    input  wire logic        penable,            // apb access phase
    input  wire logic        pwrite,             // apb write
    input  wire logic [7:0]  paddr,              // apb byte address
    input  wire logic [31:0] pwdata,             // apb write data
    output logic      [31:0] prdata,             // apb read data
    output logic             pready,             // apb ready
    output logic             pslverr,            // apb error
    input  wire logic        mem_lo_bit,         // memory lsb stream
    input  wire logic        mem_hi_bit,         // memory msb stream
    output logic             memory_shift_clock, // memory data clock
    output logic             display_row_active, // row address advance
    output logic             video_out,          // dot video, high lit
    output logic             hsync_out_n,        // horizontal sync
    output logic             vsync_out_n,        // vertical sync
    output logic             cursor_blink_tick,  // blink level
    output logic             end_message_char    // end code seen
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    logic [4:0] glyph_mem [0:511];

    // pin synchronisers for the memory streams
    logic [1:0] mem_meta_ff;
    logic [1:0] mem_sync_ff;

    // ----------------------------------------------------------------
    // register file state
    // ----------------------------------------------------------------
    logic [1:0]  ctrl_ff,   nxt_ctrl;
    cursor_pos_t cur_ff,    nxt_cur;
    logic [8:0]  gaddr_ff,  nxt_gaddr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        glyph_we;
    logic        wr_acc;
    logic        rd_setup;
    logic        hit_any;

    // ----------------------------------------------------------------
    // raster state
    // ----------------------------------------------------------------
    logic [4:0] div_ff,    nxt_div;
    logic [2:0] phase_ff,  nxt_phase;
    logic [6:0] sreg_ff,   nxt_sreg;
    logic [6:0] cnt_ff,    nxt_cnt;
    logic [3:0] ras_ff,    nxt_ras;
    logic [4:0] dline_ff,  nxt_dline;
    logic [3:0] bdiv_ff,   nxt_bdiv;
    logic       blink_ff,  nxt_blink;
    logic [2:0] glo_ff,    nxt_glo;
    logic [2:0] ghi_ff,    nxt_ghi;
    logic [5:0] code_ff,   nxt_code;
    logic       eom_ff,    nxt_eom;
    logic       video_ff,  nxt_video;
    logic       hs_ff,     nxt_hs;
    logic       vs_ff,     nxt_vs;
    logic       act_ff,    nxt_act;
    logic       mclk_ff,   nxt_mclk;
    logic       dot_en;
    logic       load;
    logic [8:0] line;
    logic [8:0] line_inc;
    logic [4:0] dots;
    logic       cur_hit;
    logic       ven;

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign pready   = 1'b1;
    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign hit_any  = reg_hit(paddr, OFF_CTRL) | reg_hit(paddr, OFF_CURSOR)
                    | reg_hit(paddr, OFF_GLYPH_ADDR) | reg_hit(paddr, OFF_GLYPH_DATA)
                    | reg_hit(paddr, OFF_STATUS);
    assign pslverr  = psel & penable & ~hit_any;
    assign prdata   = prdata_ff;
    assign glyph_we = wr_acc & reg_hit(paddr, OFF_GLYPH_DATA);

    // register writes and read data capture at setup
    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_cur    = cur_ff;
        nxt_gaddr  = gaddr_ff;
        nxt_prdata = prdata_ff;
        if (wr_acc && reg_hit(paddr, OFF_CTRL)) begin
            nxt_ctrl = pwdata[1:0];
        end
        if (wr_acc && reg_hit(paddr, OFF_CURSOR)) begin
            nxt_cur.col = pwdata[6:0];
            nxt_cur.row = pwdata[CUR_ROW_POS +: 5];
        end
        if (wr_acc && reg_hit(paddr, OFF_GLYPH_ADDR)) begin
            nxt_gaddr = pwdata[8:0];
        end
        if (glyph_we) begin
            nxt_gaddr = gaddr_ff + 9'h001;  // auto step through table
        end
        if (rd_setup) begin
            nxt_prdata = 32'h0000_0000;
            if (reg_hit(paddr, OFF_CTRL)) begin
                nxt_prdata[1:0] = ctrl_ff;
            end
            if (reg_hit(paddr, OFF_CURSOR)) begin
                nxt_prdata[6:0] = cur_ff.col;
                nxt_prdata[CUR_ROW_POS +: 5] = cur_ff.row;
            end
            if (reg_hit(paddr, OFF_GLYPH_ADDR)) begin
                nxt_prdata[8:0] = gaddr_ff;
            end
            if (reg_hit(paddr, OFF_GLYPH_DATA)) begin
                nxt_prdata[4:0] = glyph_mem[gaddr_ff];
            end
            if (reg_hit(paddr, OFF_STATUS)) begin
                nxt_prdata[8:0] = line;
                nxt_prdata[STAT_BLINK_POS] = blink_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= CTRL_RST;
            cur_ff    <= '0;
            gaddr_ff  <= 9'h000;
            prdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            cur_ff    <= nxt_cur;
            gaddr_ff  <= nxt_gaddr;
            prdata_ff <= nxt_prdata;
        end
    end
    always_ff @(posedge pclk) begin
        if (glyph_we) begin
            glyph_mem[gaddr_ff] <= pwdata[4:0];
        end
    end
    // two-stage synchroniser for memory pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_meta_ff <= 2'h0;
            mem_sync_ff <= 2'h0;
        end else begin
            mem_meta_ff <= {mem_hi_bit, mem_lo_bit};
            mem_sync_ff <= mem_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // raster timing
    // ----------------------------------------------------------------
    assign dot_en   = (div_ff == 5'(DOT_CYC - 1));
    assign line     = {dline_ff, ras_ff};
    assign line_inc = line + 9'h001;
    // reload once the sentinel reaches the last watched stage, all high
    assign load     = dot_en & (&sreg_ff[6:1]);
    // shift dots out, ones behind; reload dots, zero, sentinel
    assign nxt_sreg = load ? {1'b1, 1'b0, dots}
                    : (dot_en ? {1'b1, sreg_ff[6:1]} : sreg_ff);
    assign cur_hit  = (cur_ff.col == nxt_cnt) && (cur_ff.row == dline_ff)
                    && (blink_ff || !ctrl_ff[CTRL_BLINK_BIT]);
    // video only inside the text area
    assign ven      = (cnt_ff < CHAR_BLANK) && (line < FRAME_BLANK)
                    && ctrl_ff[CTRL_EN_BIT];

    // dot row for the raster line being loaded, stored inverted
    always_comb begin
        dots = ~glyph_mem[{code_ff, nxt_ras[2:0]}];
        if (nxt_ras >= ROW_GAP) begin
            dots = 5'h1F;
            if ((nxt_ras == CUR_LO || nxt_ras == CUR_HI) && cur_hit) begin
                dots = 5'h00;
            end
        end else if (eom_ff) begin
            // end code drawn as a lit block
            dots = 5'h00;
        end else if (nxt_ras == ROW_GAP - 4'h1) begin
            dots = 5'h1F;
        end
    end

    always_comb begin
        nxt_div   = dot_en ? 5'h00 : div_ff + 5'h01;
        nxt_phase = phase_ff;
        nxt_cnt   = cnt_ff;
        nxt_ras   = ras_ff;
        nxt_dline = dline_ff;
        nxt_bdiv  = bdiv_ff;
        nxt_blink = blink_ff;
        nxt_glo   = glo_ff;
        nxt_ghi   = ghi_ff;
        nxt_code  = code_ff;
        nxt_eom   = eom_ff;
        nxt_mclk  = mclk_ff;
        if (dot_en) begin
            nxt_phase = load ? 3'h0 : phase_ff + 3'h1;
            nxt_mclk = (nxt_phase < 3'h3);
            if (phase_ff < 3'h3) begin
                // two bits per dot tick, lsb first
                nxt_glo = {mem_sync_ff[0], glo_ff[2:1]};
                nxt_ghi = {mem_sync_ff[1], ghi_ff[2:1]};
            end
            if (phase_ff == 3'h3) begin
                nxt_code = {ghi_ff, glo_ff};
                nxt_eom  = ({ghi_ff, glo_ff} == END_MESSAGE_CODE);
            end
        end
        if (load) begin
            nxt_cnt  = cnt_ff + 7'h01;
            if (cnt_ff == CHAR_LAST) begin
                // count 100 restarts and bumps the line
                nxt_cnt = 7'h00;
                nxt_ras = ras_ff + 4'h1;
                if (ras_ff == RAS_LAST) begin
                    nxt_dline = dline_ff + 5'h01;
                end
                if (line_inc == FRAME_LINES) begin
                    nxt_ras   = 4'h0;
                    nxt_dline = 5'h00;
                    nxt_bdiv  = bdiv_ff + 4'h1;
                    if (bdiv_ff == BLINK_LAST) begin
                        nxt_bdiv  = 4'h0;
                        nxt_blink = ~blink_ff;
                    end
                end
            end
        end
    end

    // registered video and sync outputs
    always_comb begin
        nxt_act   = (cnt_ff < CHAR_BLANK);
        nxt_video = ven & ~sreg_ff[0] & (phase_ff != 3'h5);
        // hsync from count 80 for about 5 us
        nxt_hs    = ~((cnt_ff >= CHAR_BLANK) &&
                      (cnt_ff < CHAR_BLANK + 7'(HSYNC_CHARS)));
        // vsync from line 176 for about 1 ms
        nxt_vs    = ~((line >= VSYNC_LINE) &&
                      (line < VSYNC_LINE + 9'(VSYNC_LINES)));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff   <= 5'h00;
            phase_ff <= 3'h0;
            sreg_ff  <= 7'h7F;
            cnt_ff   <= 7'h00;
            ras_ff   <= 4'h0;
            dline_ff <= 5'h00;
            bdiv_ff  <= 4'h0;
            blink_ff <= 1'b0;
            glo_ff   <= 3'h0;
            ghi_ff   <= 3'h0;
            code_ff  <= 6'h00;
            eom_ff   <= 1'b0;
            mclk_ff  <= 1'b0;
            video_ff <= 1'b0;
            hs_ff    <= 1'b1;
            vs_ff    <= 1'b1;
            act_ff   <= 1'b0;
        end else begin
            div_ff   <= nxt_div;
            phase_ff <= nxt_phase;
            sreg_ff  <= nxt_sreg;
            cnt_ff   <= nxt_cnt;
            ras_ff   <= nxt_ras;
            dline_ff <= nxt_dline;
            bdiv_ff  <= nxt_bdiv;
            blink_ff <= nxt_blink;
            glo_ff   <= nxt_glo;
            ghi_ff   <= nxt_ghi;
            code_ff  <= nxt_code;
            eom_ff   <= nxt_eom;
            mclk_ff  <= nxt_mclk;
            video_ff <= nxt_video;
            hs_ff    <= nxt_hs;
            vs_ff    <= nxt_vs;
            act_ff   <= nxt_act;
        end
    end
    // output drive
    assign memory_shift_clock = mclk_ff;
    assign display_row_active = act_ff;
    assign video_out          = video_ff;
    assign hsync_out_n        = hs_ff;
    assign vsync_out_n        = vs_ff;
    assign cursor_blink_tick  = blink_ff;
    assign end_message_char   = eom_ff;
endmodule : text_raster_video

`default_nettype wire

//--- dv/text_raster_video_props.sv
`timescale 1ns/100ps
`default_nettype none

module text_raster_video_props (
    input wire logic        pclk,               // clock
    input wire logic        presetn,            // async reset
    input wire logic        psel,               // apb select
    input wire logic        penable,            // apb access
    input wire logic [7:0]  paddr,              // apb address
    input wire logic [31:0] prdata,             // apb read data
    input wire logic        pslverr,            // apb error
    input wire logic        memory_shift_clock, // memory clock
    input wire logic        display_row_active, // row active
    input wire logic        video_out,          // video
    input wire logic        hsync_out_n         // hsync
);
    // ----------------------------------------------------------------
    // level counters
    // ----------------------------------------------------------------
    logic [15:0] hs_low_ff, row_hi_ff, mck_hi_ff;
    logic [15:0] nxt_hs_low, nxt_row_hi, nxt_mck_hi;
    logic        row_arm_ff;  // first row after reset is short, skip it

    // length of the current level of each watched output
    always_comb begin
        nxt_hs_low = hsync_out_n ? 16'h0000 : hs_low_ff + 16'h0001;
        nxt_row_hi = display_row_active ? row_hi_ff + 16'h0001 : 16'h0000;
        nxt_mck_hi = memory_shift_clock ? mck_hi_ff + 16'h0001 : 16'h0000;
    end

    // register the counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_low_ff <= 16'h0000;
            row_hi_ff <= 16'h0000;
            mck_hi_ff <= 16'h0000;
            row_arm_ff <= 1'b0;
        end else begin
            row_arm_ff <= row_arm_ff | ~hsync_out_n;
            hs_low_ff <= nxt_hs_low;
            row_hi_ff <= nxt_row_hi;
            mck_hi_ff <= nxt_mck_hi;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_hs_width;
        $rose(hsync_out_n) |-> hs_low_ff == 16'h03F0;
    endproperty
    a_hs_width: assert property (p_hs_width) else $error("hsync width off");

    property p_row_width;
        $fell(display_row_active) && row_arm_ff |-> row_hi_ff == 16'h2760;
    endproperty
    a_row_width: assert property (p_row_width) else $error("row width off");

    property p_mck_width;
        $fell(memory_shift_clock) |-> mck_hi_ff == 16'h003F;
    endproperty
    a_mck_width: assert property (p_mck_width) else $error("mem clock off");

    property p_hs_blank;
        !hsync_out_n |-> !display_row_active && !video_out;
    endproperty
    a_hs_blank: assert property (p_hs_blank) else $error("lit in retrace");

    property p_fall_pair;
        $fell(hsync_out_n) |-> $fell(display_row_active);
    endproperty
    a_fall_pair: assert property (p_fall_pair) else $error("sync not at 80");

    property p_video_row;
        video_out |-> display_row_active;
    endproperty
    a_video_row: assert property (p_video_row) else $error("video off row");

    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    a_err_phase: assert property (p_err_phase) else $error("stray error");

    property p_unmapped;
        psel && penable && paddr > 8'h10 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped ok");

    c_hsync: cover property ($rose(hsync_out_n));
    c_lit: cover property ($rose(video_out));
    c_err: cover property (pslverr);
endmodule : text_raster_video_props

bind text_raster_video text_raster_video_props i_text_raster_video_props (
    .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pslverr,
    .memory_shift_clock, .display_row_active, .video_out, .hsync_out_n
);

`default_nettype wire

//--- dv/crt_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module crt_monitor (
    input  wire logic        pclk,    // sampling clock
    input  wire logic        video,   // dot video
    input  wire logic        hsync_n, // horizontal sync
    output var  logic        rpt,     // line report
    output var  logic [31:0] lit_cyc, // lit cycles of line
    output var  logic [31:0] low_cyc, // last sync width
    output var  logic [31:0] per_cyc  // sync period
);
    logic [31:0] lit_c, low_c, low_l, per_c;
    logic        hs_d;

    // start quiet
    initial begin
        {rpt, lit_cyc, low_cyc, per_cyc, lit_c, low_c, low_l, per_c} = '0;
        hs_d = 1'b1;
    end

    always @(posedge pclk) begin
        hs_d <= hsync_n;
        rpt <= 1'b0;
        per_c <= per_c + 1;
        if (video === 1'b1) lit_c <= lit_c + 1;
        if (hsync_n === 1'b0) low_c <= low_c + 1;
        else if (low_c != 0) begin
            low_l <= low_c;
            low_c <= 0;
        end
        if (hs_d && hsync_n === 1'b0) begin
            rpt <= 1'b1;
            lit_cyc <= lit_c;
            low_cyc <= low_l;
            per_cyc <= per_c + 1;
            lit_c <= 0;
            per_c <= 0;
        end
    end
endmodule : crt_monitor

`default_nettype wire

//--- dv/text_raster_video_tb.sv
`timescale 1ns/100ps
`default_nettype none

module text_raster_video_tb
    import char_video_pkg::*;
;
    logic         pclk, presetn, psel, penable, pwrite, mem_lo_bit, mem_hi_bit;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, lit_cyc, low_cyc, per_cyc;
    logic         pready, pslverr, memory_shift_clock, display_row_active, rpt;
    logic         video_out, hsync_out_n, vsync_out_n, cursor_blink_tick, end_message_char;
    logic [32:0]  rd_q[$];
    logic [127:0] ln_q[$];
    logic [127:0] le, ln_e;
    logic [4:0]   glyph[8];
    int           num_errors = 0;
    int           tests_run = 0;

    text_raster_video i_text_raster_video (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .mem_lo_bit, .mem_hi_bit, .memory_shift_clock, .display_row_active,
        .video_out, .hsync_out_n, .vsync_out_n, .cursor_blink_tick, .end_message_char
    );

    crt_monitor i_crt_monitor (
        .pclk, .video(video_out), .hsync_n(hsync_out_n), .rpt, .lit_cyc, .low_cyc, .per_cyc
    );

    // clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks=%0d errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // one apb transfer; a read notes {pslverr, prdata}
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) rd_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            close_out();
        end
        @(posedge pclk);
    endtask : apb

    task automatic wait_rpt();
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rpt !== 1'b1 && n < 20000);
        if (rpt !== 1'b1) begin
            num_errors++;
            close_out();
        end
        @(posedge pclk);
    endtask : wait_rpt

    function automatic logic [127:0] line_exp(input logic end_message_code, input int dots);
        return {30'h0, 1'b1, end_message_code, dots * 32'h690, 32'h3F0, 32'h3138};
    endfunction : line_exp

    // take the oldest note when a result appears
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
            check({95'h0, pslverr, prdata}, {95'h0, rd_q.pop_front()});
        end
        if (rpt && ln_q.size() > 0) begin
            le = {30'h0, vsync_out_n, end_message_char, lit_cyc, low_cyc, per_cyc};
            check(le, ln_q.pop_front());
        end
    end

    // main sequence
    initial begin
        {psel, penable, pwrite, mem_lo_bit, mem_hi_bit} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        void'($urandom(32'h0E004494));
        for (int i = 0; i < 8; i++) glyph[i] = 5'($urandom());
        glyph[1] = 5'h1F;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFF_CTRL, 32'h0, {31'h0, CTRL_RST});
        apb(1'b0, OFF_STATUS, 32'h0, 33'h0);
        apb(1'b0, 8'h14, 32'h0, 33'h100000000);
        apb(1'b1, OFF_CURSOR, 32'h305, 33'h0);
        apb(1'b0, OFF_CURSOR, 32'h0, 33'h305);
        apb(1'b1, OFF_GLYPH_ADDR, 32'h0, 33'h0);
        for (int i = 0; i < 8; i++) apb(1'b1, OFF_GLYPH_DATA, {27'h0, glyph[i]}, 33'h0);
        apb(1'b0, OFF_GLYPH_ADDR, 32'h0, 33'h8);
        apb(1'b1, OFF_GLYPH_ADDR, 32'h1, 33'h0);
        apb(1'b0, OFF_GLYPH_DATA, 32'h0, 33'h1F);
        $display("test regs done");
        wait_rpt();
        for (int k = 1; k < 8; k++) begin
            apb(1'b0, OFF_STATUS, 32'h0, 33'(k - 1));
            if (k == 3) apb(1'b1, OFF_CTRL, 32'h2, 33'h0);
            if (k == 4) begin
                apb(1'b1, OFF_CTRL, 32'h3, 33'h0);
                mem_lo_bit <= 1'b1;
                mem_hi_bit <= 1'b1;
            end
            // line 1 is all ones, line 3 disabled, then end code block
            ln_e = line_exp(1'b0, $countones(glyph[k]));
            if (k == 3) ln_e = line_exp(1'b0, 0);
            if (k > 3) ln_e = line_exp(1'b1, 5);
            ln_q.push_back(ln_e);
            wait_rpt();
        end
        $display("test lines done");
        close_out();
    end
endmodule : text_raster_video_tb

`default_nettype wire
